/* dxt_pkg.sv */
package dxt_pkg;

	// Operation modes selected by the mode bits of each timer.
	typedef enum logic [2:0] {
		DXT_MODE_TIMER,
		DXT_MODE_EVENT,
		DXT_MODE_PULSE,
		DXT_MODE_PERIOD,
		DXT_MODE_WIDTH,
		DXT_MODE_WAVE,
		DXT_MODE_ONESHOT,
		DXT_MODE_PWM
	} dxt_mode_t;

	// Count source selection codes.
	localparam logic [1:0] DXT_SRC_DIV2 = 2'h0;
	localparam logic [1:0] DXT_SRC_DIV8 = 2'h1;
	localparam logic [1:0] DXT_SRC_DIV16 = 2'h2;
	localparam logic [1:0] DXT_SRC_PIN = 2'h3;

	// Oscillator division ratios for the internal count sources.
	localparam int DXT_DIV_A = 2;
	localparam int DXT_DIV_B = 8;
	localparam int DXT_DIV_C = 16;
	localparam int DXT_PRESCALE_W = 4;

	// Reset and boundary values of the counter, latch and byte buffers.
	localparam logic [15:0] DXT_CNT_RESET = 16'hFFFF;
	localparam logic [15:0] DXT_LATCH_RESET = 16'hFFFF;
	localparam logic [15:0] DXT_CNT_WRAP = 16'hFFFF;
	localparam logic [15:0] DXT_CNT_ZERO = 16'h0000;
	localparam logic [7:0] DXT_PWM_ONE = 8'h01;
	localparam logic [7:0] DXT_BYTE_RESET = 8'h00;

	// Per-timer configuration, all static control bits.
	typedef struct packed {
		dxt_mode_t mode;
		logic [1:0] src_sel;
		logic latch_only;
		logic edge_sel;
		logic stop;
	} dxt_cfg_t;

	// Byte-wide CPU access to one timer.
	typedef struct packed {
		logic wr_lo;
		logic wr_hi;
		logic rd_hi;
		logic [7:0] wdata;
	} dxt_cpu_t;

endpackage

/* dxt_timer.sv */

////////////////////////////////////////////////////////////////////////////////

module dxt_timer
	import dxt_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [DXT_PRESCALE_W-1:0] prescale,
	input wire dxt_cfg_t cfg,
	input wire dxt_cpu_t cpu,
	input wire logic pin_in,
	output logic [15:0] read_value,
	output logic [7:0] read_lo_buf,
	output logic underflow,
	output logic pin_out,
	output logic pin_oe
);

	logic pin_s1_q, pin_s2_q;
	logic src_q, src_d;
	logic run_q, run_d;
	logic [15:0] cnt_q, cnt_d;
	logic [15:0] reload_value_q, reload_value_d;
	logic [7:0] wbuf_q, wbuf_d;
	logic [7:0] rbuf_q, rbuf_d;
	logic uf_q, uf_d;
	logic pout_q, pout_d;
	logic src_now, tick, measure;

	function automatic logic src_level(input logic [1:0] sel,
		input logic [DXT_PRESCALE_W-1:0] p, input logic pin,
		input logic is_event);
		case (sel)
			DXT_SRC_DIV2: src_level = p[$clog2(DXT_DIV_A)-1];
			DXT_SRC_DIV8: src_level = p[$clog2(DXT_DIV_B)-1];
			DXT_SRC_DIV16: src_level = p[$clog2(DXT_DIV_C)-1];
			default: src_level = is_event ? pin : 1'b0;
		endcase
	endfunction

	// True in the two measurement modes, where reads see the latch.
	function automatic logic is_measure(input dxt_mode_t m);
		is_measure = (m == DXT_MODE_PERIOD) || (m == DXT_MODE_WIDTH);
	endfunction

	// The slowest internal source needs a prescaler bit of its own.
	// A narrower prescaler would silently turn /16 into a faster source.
	initial begin
		if (DXT_PRESCALE_W < $clog2(DXT_DIV_C))
			$error("Prescaler too narrow for the slowest source.");
	end

	// The event pin is asynchronous to the clock. Two flip-flops stand
	// between the pin and any logic, so a level that changes near the
	// clock edge cannot reach the edge detector half resolved.
	// The edge detector only ever reads the second stage.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////

	// Source edge detection. The stop bit only takes effect while the
	// source is high, so a stop never cuts a source pulse in half and a
	// start never produces a tick from a source that is already high.
	always_comb begin
		measure = is_measure(cfg.mode);
		// The pin only serves as a source in event count mode.
		src_now = src_level(
			cfg.src_sel,
			prescale,
			pin_s2_q ^ cfg.edge_sel,
			cfg.mode == DXT_MODE_EVENT);
		// Run state follows the stop bit only while the source is high.
		run_d = src_now ? !cfg.stop : run_q;
		src_d = src_now;
		tick = src_now && !src_q && run_q;
	end

	// Counter, latch and byte buffers. A tick moves the counter first;
	// a high-byte write with write control 0 then overrides it, so a
	// write that meets an underflow leaves the written value behind.
	// The underflow pulse itself still goes out in that case.
	always_comb begin
		cnt_d = cnt_q;
		reload_value_d = reload_value_q;
		wbuf_d = wbuf_q;
		rbuf_d = rbuf_q;
		uf_d = 1'b0;
		pout_d = pout_q;
		if (tick) begin
			// In PWM mode each byte is its own 8-bit counter; reaching one
			// in either byte ends the period at the next tick.
			if (cfg.mode == DXT_MODE_PWM) begin
				if (cnt_q[15:8] == DXT_PWM_ONE || cnt_q[7:0] == DXT_PWM_ONE) begin
					cnt_d = reload_value_q;
					uf_d = 1'b1;
				end else begin
					cnt_d = {cnt_q[15:8] - 8'h01, cnt_q[7:0] - 8'h01};
				end
			end else if (cnt_q == DXT_CNT_ZERO) begin
				// Measurement modes wrap to all ones; the others reload
				// from the latch that software last wrote.
				uf_d = 1'b1;
				cnt_d = measure ? DXT_CNT_WRAP : reload_value_q;
			end else begin
				cnt_d = cnt_q - 16'h0001;
			end
		end
		if (uf_d && cfg.mode == DXT_MODE_PULSE)
			pout_d = !pout_q;
		// Writes. The low byte is parked in its own buffer so that the
		// running counter is not disturbed between the two byte writes.
		// Only the high-byte write moves the latch, and the counter too while latch_only is 0.
		// The low byte only waits; counting continues meanwhile.
		if (cpu.wr_lo)
			wbuf_d = cpu.wdata;
		if (cpu.wr_hi) begin
			reload_value_d = {cpu.wdata, wbuf_q};
			if (!cfg.latch_only) begin
				cnt_d = {cpu.wdata, wbuf_q};
				pout_d = !cfg.edge_sel;
			end
		end
		// The low byte is frozen at the high-byte read, so the pair that
		// software reads belongs to one instant.
		if (cpu.rd_hi) begin
			rbuf_d = measure ? reload_value_q[7:0]
				: cnt_q[7:0];
		end
	end

	// Timer state registers. The pin output leaves reset high, the
	// level that a direct write with edge select 0 would preset.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			src_q <= 1'b0;
			run_q <= 1'b0;
			cnt_q <= DXT_CNT_RESET;
			reload_value_q <= DXT_LATCH_RESET;
			wbuf_q <= DXT_BYTE_RESET;
			rbuf_q <= DXT_BYTE_RESET;
			uf_q <= 1'b0;
			pout_q <= 1'b1;
		end else begin
			src_q <= src_d;
			run_q <= run_d;
			cnt_q <= cnt_d;
			reload_value_q <= reload_value_d;
			wbuf_q <= wbuf_d;
			rbuf_q <= rbuf_d;
			uf_q <= uf_d;
			pout_q <= pout_d;
		end
	end

	// Latch is only visible through reads in the measurement modes.
	assign read_value = measure ? reload_value_q : cnt_q;
	assign read_lo_buf = rbuf_q;
	assign underflow = uf_q;
	assign pin_out = pout_q;
	assign pin_oe = (cfg.mode == DXT_MODE_PULSE);

endmodule // dxt_timer

////////////////////////////////////////////////////////////////////////////////

module dxt_top
	import dxt_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire dxt_cfg_t cfg_x,
	input wire dxt_cfg_t cfg_y,
	input wire dxt_cpu_t cpu_x,
	input wire dxt_cpu_t cpu_y,
	input wire logic irq_clr_x,
	input wire logic irq_clr_y,
	input wire logic event_pin_x_in,
	input wire logic event_pin_y_in,
	output logic event_pin_x_out,
	output logic event_pin_x_oe,
	output logic event_pin_y_out,
	output logic event_pin_y_oe,
	output logic [7:0] rdata_x_q,
	output logic [7:0] rdata_y_q,
	output logic irq_x_q,
	output logic irq_y_q
);

	logic [DXT_PRESCALE_W-1:0] pre_q, pre_d;
	logic [15:0] val_x, val_y;
	logic [7:0] lo_x, lo_y;
	logic uf_x, uf_y;
	logic pox, poex, poy, poey;
	logic [7:0] rdx_d, rdy_d;
	logic irqx_d, irqy_d;
	logic [3:0] pins_q, pins_d;

	initial begin
		if (DXT_PRESCALE_W < $clog2(DXT_DIV_C))
			$error("Prescaler too narrow for the slowest source.");
	end

	// Shared prescaler. Both timers tap the same free-running counter,
	// so their internal sources stay in step with each other.
	always_comb begin
		pre_d = pre_q + 1'b1;
		// High-byte read returns the counter, or the latch in measurement modes; low read returns the buffer.
		rdx_d = cpu_x.rd_hi ? val_x[15:8] : lo_x;
		rdy_d = cpu_y.rd_hi ? val_y[15:8] : lo_y;
		// A new underflow wins over a software clear.
		irqx_d = uf_x | (irq_x_q & !irq_clr_x);
		irqy_d = uf_y | (irq_y_q & !irq_clr_y);
		pins_d = {pox, poex, poy, poey};
	end

	// Every output of the block leaves from one of these flip-flops.
	// Reset shows both pins high and both enables low.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pre_q <= '0;
			rdata_x_q <= 8'h00;
			rdata_y_q <= 8'h00;
			irq_x_q <= 1'b0;
			irq_y_q <= 1'b0;
			pins_q <= 4'hA;
		end else begin
			pre_q <= pre_d;
			rdata_x_q <= rdx_d;
			rdata_y_q <= rdy_d;
			irq_x_q <= irqx_d;
			irq_y_q <= irqy_d;
			pins_q <= pins_d;
		end
	end

	// Pin levels and enables, one register stage behind the timers.
	// A preset or toggle therefore shows on the pin one cycle later.
	assign event_pin_x_out = pins_q[3];
	assign event_pin_x_oe = pins_q[2];
	assign event_pin_y_out = pins_q[1];
	assign event_pin_y_oe = pins_q[0];

	// Timer X serves the first event pin.
	dxt_timer u_tx (
		.clock(clock),
		.arst_n(arst_n),
		.prescale(pre_q),
		.cfg(cfg_x),
		.cpu(cpu_x),
		.pin_in(event_pin_x_in),
		.read_value(val_x),
		.read_lo_buf(lo_x),
		.underflow(uf_x),
		.pin_out(pox),
		.pin_oe(poex)
	);

	// Timer Y serves the second event pin.
	dxt_timer u_ty (
		.clock(clock),
		.arst_n(arst_n),
		.prescale(pre_q),
		.cfg(cfg_y),
		.cpu(cpu_y),
		.pin_in(event_pin_y_in),
		.read_value(val_y),
		.read_lo_buf(lo_y),
		.underflow(uf_y),
		.pin_out(poy),
		.pin_oe(poey)
	);

endmodule // dxt_top

/* dxt_checker.sv */
module dxt_checker
	import dxt_pkg::*;
(
	input logic clock,
	input logic arst_n,
	input dxt_cfg_t cfg_x,
	input dxt_cfg_t cfg_y,
	input dxt_cpu_t cpu_x,
	input dxt_cpu_t cpu_y,
	input logic irq_clr_x,
	input logic irq_clr_y,
	input logic event_pin_y_out,
	input logic event_pin_x_oe,
	input logic event_pin_y_oe,
	input logic [7:0] rdata_x_q,
	input logic [7:0] rdata_y_q,
	input logic irq_x_q,
	input logic irq_y_q
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	logic [4:0] stop_cnt_y_q;
	// Counts cycles with timer Y stopped, saturating well past /16.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			stop_cnt_y_q <= 5'h00;
		else if (!cfg_y.stop)
			stop_cnt_y_q <= 5'h00;
		else if (stop_cnt_y_q != 5'h14)
			stop_cnt_y_q <= stop_cnt_y_q + 5'h01;
	end
	a_irq_hold_x: assert property (
		irq_x_q && !irq_clr_x |=> irq_x_q) else $error("irq x lost");
	a_irq_hold_y: assert property (
		irq_y_q && !irq_clr_y |=> irq_y_q) else $error("irq y lost");
	a_oe_mode_x: assert property (
		1 |=> event_pin_x_oe == ($past(cfg_x.mode) == DXT_MODE_PULSE))
		else $error("oe x wrong");
	a_oe_mode_y: assert property (
		1 |=> event_pin_y_oe == ($past(cfg_y.mode) == DXT_MODE_PULSE))
		else $error("oe y wrong");
	a_read_hold_x: assert property (
		!cpu_x.rd_hi ##1 !cpu_x.rd_hi |=> $stable(rdata_x_q))
		else $error("read x moved");
	a_read_hold_y: assert property (
		!cpu_y.rd_hi ##1 !cpu_y.rd_hi |=> $stable(rdata_y_q))
		else $error("read y moved");
	a_preset_y: assert property (
		cpu_y.wr_hi && !cfg_y.latch_only && cfg_y.mode == DXT_MODE_PULSE
		|=> ##1 event_pin_y_out == !cfg_y.edge_sel)
		else $error("preset wrong");
	a_stop_halt_y: assert property (
		stop_cnt_y_q == 5'h14 |-> !$rose(irq_y_q)) else $error("stopped irq");
endmodule // dxt_checker

/* dxt_pulse_src.sv */
module dxt_pulse_src (
	input logic clock,
	input logic run,
	output logic pin_x,
	output logic pin_y
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] n = 3'h0;
	// Pin x runs at a quarter of the clock, pin y at an eighth; idle low.
	always @(posedge clock) n <= run ? n + 3'h1 : 3'h0;
	assign pin_x = run & n[1];
	assign pin_y = run & n[2];
endmodule // dxt_pulse_src

/* dual_16bit_reload_timer_test.sv */
module dual_16bit_reload_timer_test
	import dxt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic run = 1'b0;
	logic [1:0] ic = 2'h0;
	dxt_cfg_t g [2];
	dxt_cpu_t c [2];
	wire [7:0] rd [2];
	wire [1:0] irq, po, oe, pin;
	int fails = 0;
	int checked = 0;
	int n;
	logic [15:0] v;
	always #50 clock = ~clock;
	dxt_top dxt_top_inst (.clock, .arst_n, .cfg_x(g[0]), .cfg_y(g[1]),
		.cpu_x(c[0]), .cpu_y(c[1]), .irq_clr_x(ic[0]), .irq_clr_y(ic[1]),
		.event_pin_x_in(pin[0]), .event_pin_y_in(pin[1]),
		.event_pin_x_out(po[0]), .event_pin_x_oe(oe[0]),
		.event_pin_y_out(po[1]), .event_pin_y_oe(oe[1]),
		.rdata_x_q(rd[0]), .rdata_y_q(rd[1]), .irq_x_q(irq[0]),
		.irq_y_q(irq[1]));
	dxt_pulse_src dxt_pulse_src_inst (.clock, .run, .pin_x(pin[0]),
		.pin_y(pin[1]));
	task step();
		@(posedge clock);
		#1;
	endtask
	task cfg(input int t, input dxt_mode_t m, input logic [1:0] s,
		input logic l, input logic e, input logic p);
		g[t] = '{m, s, l, e, p};
	endtask
	task wr(input int t, input logic [15:0] w);
		c[t] = '{1'b1, 1'b0, 1'b0, w[7:0]};
		step();
		c[t] = '{1'b0, 1'b1, 1'b0, w[15:8]};
		step();
		c[t].wr_hi = 1'b0;
	endtask
	task rdv(input int t);
		c[t].rd_hi = 1'b1;
		step();
		c[t].rd_hi = 1'b0;
		v[15:8] = rd[t];
		step();
		v[7:0] = rd[t];
	endtask
	task irqw(input int t, input int lim);
		ic[t] = 1'b1;
		step();
		ic[t] = 1'b0;
		n = 0;
		while (irq[t] !== 1'b1 && n < lim) begin
			step();
			n++;
		end
	endtask
	task chk(input logic [15:0] a, input logic [15:0] e);
		checked++;
		if (a !== e) begin
			fails++;
			$display("CHECK FAILED at %0t: %h not %h", $time, a, e);
		end
	endtask
	task end_of_test();
		$display("fails %0d checked %0d", fails, checked);
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#1000000;
		fails++;
		end_of_test();
	end
	initial begin
		c[0] = '0;
		c[1] = '0;
		cfg(0, DXT_MODE_TIMER, DXT_SRC_DIV2, 0, 0, 1);
		cfg(1, DXT_MODE_TIMER, DXT_SRC_DIV2, 0, 0, 1);
		repeat (5) step();
		arst_n = 1'b1;
		chk(16'({irq, oe, po}), 16'h0003);
		wr(0, 16'h0100);
		rdv(0);
		chk(v, 16'h0100);
		g[0].latch_only = 1'b1;
		wr(0, 16'h0005);
		rdv(0);
		chk(v, 16'h0100);
		g[0].stop = 1'b0;
		irqw(0, 600);
		chk(16'(n inside {[505:530]}), 16'h0001);
		irqw(0, 30);
		chk(16'(n inside {[6:14]}), 16'h0001);
		cfg(0, DXT_MODE_PERIOD, DXT_SRC_DIV2, 1, 0, 1);
		rdv(0);
		chk(v, 16'h0005);
		cfg(0, DXT_MODE_PWM, DXT_SRC_DIV8, 0, 0, 1);
		wr(0, 16'h0302);
		g[0].stop = 1'b0;
		irqw(0, 40);
		chk(16'(n < 30), 16'h0001);
		cfg(1, DXT_MODE_PULSE, DXT_SRC_DIV16, 0, 1, 1);
		wr(1, 16'h0001);
		step();
		chk(16'({oe[1], po[1]}), 16'h0002);
		rdv(1);
		chk(v, 16'h0001);
		g[1].stop = 1'b0;
		irqw(1, 80);
		chk(16'({n < 60, po[1]}), 16'h0003);
		cfg(1, DXT_MODE_EVENT, DXT_SRC_PIN, 0, 1, 1);
		wr(1, 16'h0002);
		g[1].stop = 1'b0;
		run = 1'b1;
		irqw(1, 60);
		chk(16'(n < 50), 16'h0001);
		chk(16'({oe[0], po[0]}), 16'h0001);
		end_of_test();
	end
endmodule // dual_16bit_reload_timer_test
bind dxt_top dxt_checker dxt_checker_inst (.clock, .arst_n, .cfg_x, .cfg_y,
	.cpu_x, .cpu_y, .irq_clr_x, .irq_clr_y, .event_pin_y_out,
	.event_pin_x_oe, .event_pin_y_oe, .rdata_x_q, .rdata_y_q, .irq_x_q,
	.irq_y_q);
